//--- cip_controller.sv
`timescale 1ns/100ps
`default_nettype none
`include "cip_defines.svh"
module cip_controller (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_b,
  // processor bus, one-cycle strobes
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  input  wire logic              addr0,
  input  wire cip_pkg::cip_byte_t wdata,
  output var  cip_pkg::cip_byte_t rdata,
  // acknowledge cycle, active low level
  input  wire logic              interrupt_acknowledge_in_b,
  output var  cip_pkg::cip_byte_t vec_data,
  output var  logic              vec_valid,
  // requests and request output
  input  wire logic [7:0]        req_in,
  output logic                   int_out,
  // cascade
  input  wire logic              master_slave_select,
  input  wire logic [2:0]        cas_in,
  output var  logic [2:0]        cas_out,
  output var  logic              cas_oe,
  // status
  output logic                   init_done
);
  import cip_pkg::*;

  cip_init_t  init_r, init_nxt;
  cip_ack_t   ack_r, ack_nxt;
  logic       single_r, intv4_r, poll_arm_r;
  cip_byte_t  base_r, casc_r;
  cip_byte_t  request_mask_register;
  cip_byte_t  pend_r, serv_r;
  logic [7:0] req_q_r;
  logic [2:0] ack_lvl_r;
  logic       ack_mine_r;

  wire w_one   = wr_stb && !addr0 && wdata[`CIP_W1_MARK_BIT];
  wire w_cmd   = wr_stb && !addr0 && !wdata[`CIP_W1_MARK_BIT];
  wire w_hi    = wr_stb && addr0;
  wire w_eoi   = w_cmd && !wdata[`CIP_CMD_MARK_BIT]
                 && wdata[`CIP_CMD_EOI_BIT];
  wire w_pollc = w_cmd && wdata[`CIP_CMD_MARK_BIT]
                 && wdata[`CIP_CMD_POLL_BIT];
  wire ready   = (init_r == CIP_READY);
  // master when select is high or single flag set
  wire is_mast = master_slave_select || single_r;

  wire [7:0] edge_req = req_in & ~req_q_r;
  wire [7:0] live     = pend_r & ~request_mask_register;
  wire       hit;
  wire [2:0] lvl;

  cip_resolver u_res (
    .pend (live),
    .serv (serv_r),
    .hit  (hit),
    .lvl  (lvl)
  );

  // highest-priority (lowest index) in-service level for end of service
  function automatic logic [7:0] clr_low(input logic [7:0] v);
    logic [7:0] r;
    logic       done;
    r = v;
    done = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (!done && v[i]) begin
        r[i] = 1'b0;
        done = 1'b1;
      end
    end
    return r;
  endfunction : clr_low

  // output can feed an upper-tier device's request input
  assign int_out   = ready && hit;
  assign init_done = ready;

  wire ack_lo  = !interrupt_acknowledge_in_b;
  wire ack_beg = ready && ack_lo && (ack_r == CIP_ACK_IDLE);
  // slave answers when its id matches the master's cascade code
  wire slv_sel = (cas_in == casc_r[2:0]);
  wire ack_mine = is_mast ? !(casc_r[lvl] && !single_r) : slv_sel;
  // master with a slave on this input broadcasts the code and gives no vector
  wire ack_casc = is_mast && !single_r && casc_r[lvl];

  wire [7:0] vec4 = 8'(base_r + ({5'h00, ack_lvl_r} << `CIP_SPACE4_SHIFT));
  wire [7:0] vec8 = 8'(base_r + ({5'h00, ack_lvl_r} << `CIP_SPACE8_SHIFT));
  wire [7:0] vec_sel = intv4_r ? vec4 : vec8;

  // init sequence
  always_comb begin
    init_nxt = init_r;
    if (w_one) begin
      init_nxt = CIP_WAIT_TWO;
    end else if (w_hi && init_r == CIP_WAIT_TWO) begin
      // single skips third word
      init_nxt = single_r ? CIP_READY : CIP_WAIT_THREE;
    end else if (w_hi && init_r == CIP_WAIT_THREE) begin
      init_nxt = CIP_READY;
    end
  end

  always_comb begin
    ack_nxt = ack_r;
    unique case (ack_r)
      CIP_ACK_IDLE: if (ack_beg) begin
        ack_nxt = CIP_ACK_LOW;
      end
      CIP_ACK_LOW: if (!ack_lo) begin
        ack_nxt = CIP_ACK_HIGH;
      end
      CIP_ACK_HIGH: ack_nxt = CIP_ACK_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      init_r <= CIP_UNINIT;
      ack_r  <= CIP_ACK_IDLE;
    end else begin
      init_r <= init_nxt;
      ack_r  <= ack_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      single_r <= 1'b0;
      intv4_r  <= 1'b0;
      base_r   <= `CIP_BASE_RST;
      casc_r   <= `CIP_CASC_RST;
    end else if (w_one) begin
      single_r <= wdata[`CIP_W1_SINGLE_BIT];
      intv4_r  <= wdata[`CIP_W1_INTV4_BIT];
    end else if (w_hi && init_r == CIP_WAIT_TWO) begin
      base_r <= wdata;
    end else if (w_hi && init_r == CIP_WAIT_THREE) begin
      casc_r <= wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      request_mask_register <= `CIP_MASK_RST;
    end else if (w_one) begin
      request_mask_register <= 8'h00;
    end else if (w_hi && ready) begin
      request_mask_register <= wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      req_q_r <= 8'h00;
    end else begin
      req_q_r <= req_in;
    end
  end

  // pending: new edges win over clears
  // a master with a slave on the input marks it in service too
  wire       take_ack = ack_beg && hit && (ack_mine || ack_casc);
  wire       take_pol = poll_arm_r && rd_stb && hit;
  wire [7:0] take     = (take_ack || take_pol) ? (8'h01 << lvl) : 8'h00;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pend_r <= 8'h00;
      serv_r <= 8'h00;
    end else if (w_one) begin
      pend_r <= 8'h00;
      serv_r <= 8'h00;
    end else begin
      pend_r <= (pend_r & ~take & req_in) | edge_req;
      serv_r <= (w_eoi ? clr_low(serv_r) : serv_r) | take;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      poll_arm_r <= 1'b0;
    end else begin
      poll_arm_r <= w_pollc ? 1'b1 : (rd_stb ? 1'b0 : poll_arm_r);
    end
  end

  // poll word needs no acknowledge pulse
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      if (poll_arm_r) begin
        rdata <= {hit, 4'h0, lvl};
      end else begin
        rdata <= addr0 ? request_mask_register : pend_r;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ack_lvl_r <= 3'h0;
      vec_data  <= 8'h00;
      vec_valid <= 1'b0;
      cas_out   <= 3'h0;
      cas_oe    <= 1'b0;
    end else begin
      if (ack_beg) begin
        ack_lvl_r <= lvl;
        cas_out   <= lvl;
        cas_oe    <= ack_casc;
      end else if (ack_r == CIP_ACK_HIGH) begin
        cas_oe    <= 1'b0;
      end
      vec_valid <= (ack_r == CIP_ACK_LOW) && ack_lo && ack_mine_r;
      vec_data  <= vec_sel;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ack_mine_r <= 1'b0;
    end else if (ack_beg) begin
      ack_mine_r <= ack_mine && !ack_casc;
    end
  end

  // assertions
  vec_space_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    vec_valid && intv4_r |-> vec_data == 8'(base_r + 8'(ack_lvl_r) * 4))
    else $error("vector spacing wrong");
  single_ready_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    single_r && w_hi && init_r == CIP_WAIT_TWO |=> init_r == CIP_READY)
    else $error("single device waits for third word");
  zero_first_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    live[0] && serv_r == 8'h00 |-> hit && lvl == 3'h0)
    else $error("input zero not first");
  poll_word_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    poll_arm_r && rd_stb |=> rdata[7] == $past(hit))
    else $error("poll word flag wrong");
  int_gate_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    int_out |-> ready && live != 8'h00)
    else $error("request out without cause");
  casc_master_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    cas_oe |-> is_mast)
    else $error("slave drives cascade");
  nest_block_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    serv_r[0] |-> !int_out)
    else $error("nesting broken");
  poll_take_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    poll_arm_r && rd_stb && hit && !w_one |=> serv_r[$past(lvl)])
    else $error("poll did not mark service");
  casc_serv_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    ack_beg && hit && ack_casc && !w_one |=> serv_r[$past(lvl)])
    else $error("cascaded level not marked in service");
  init_c: cover property (@(posedge clock) disable iff (!rst_b)
    init_r == CIP_WAIT_THREE ##1 init_r == CIP_READY);
  vec_c: cover property (@(posedge clock) disable iff (!rst_b) vec_valid);
  poll_c: cover property (@(posedge clock) disable iff (!rst_b)
    poll_arm_r && rd_stb && hit);
endmodule : cip_controller
`default_nettype wire

//--- cip_defines.svh
`ifndef CIP_DEFINES_SVH
`define CIP_DEFINES_SVH
// first initialization word fields
`define CIP_W1_MARK_BIT   4
`define CIP_W1_SINGLE_BIT 1
`define CIP_W1_INTV4_BIT  2
`define CIP_W1_W4_BIT     0
// command word fields
`define CIP_CMD_MARK_BIT  3
`define CIP_CMD_POLL_BIT  2
`define CIP_CMD_EOI_BIT   5
`define CIP_CMD_EOI_LOW   3'h0
// poll status word fields
`define CIP_POLL_REQ_BIT  7
// reset values
`define CIP_MASK_RST      8'hFF
`define CIP_BASE_RST      8'h00
`define CIP_CASC_RST      8'h00
// vector spacing
`define CIP_SPACE4_SHIFT  2
`define CIP_SPACE8_SHIFT  3
`endif

//--- cip_pkg.sv
package cip_pkg;
  typedef enum logic [1:0] {
    CIP_UNINIT,
    CIP_WAIT_TWO,
    CIP_WAIT_THREE,
    CIP_READY
  } cip_init_t;
  typedef enum logic [1:0] {
    CIP_ACK_IDLE,
    CIP_ACK_LOW,
    CIP_ACK_HIGH
  } cip_ack_t;
  typedef logic [7:0] cip_byte_t;
endpackage : cip_pkg

//--- cip_resolver.sv
`timescale 1ns/100ps
`default_nettype none
module cip_resolver (
  // request and service state
  input  wire logic [7:0] pend,
  input  wire logic [7:0] serv,
  // result
  output logic            hit,
  output logic [2:0]      lvl
);
  // fixed priority, lowest index wins; blocked by equal or higher in service
  function automatic logic [3:0] first_set(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : first_set

  wire [3:0] req_first;
  wire [3:0] srv_first;
  assign req_first = first_set(pend);
  assign srv_first = first_set(serv);
  assign hit       = (req_first != 4'h8) && (req_first < srv_first);
  assign lvl       = req_first[2:0];
endmodule : cip_resolver
`default_nettype wire

//--- cip_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module cip_host_model #(
  parameter int ACK_CYC = 6
) (
  // clock and start
  input  wire logic               clock,
  input  wire logic               go,
  input  wire logic               init_done,
  // acknowledge cycle
  output var  logic               ack_b,
  input  wire logic               vec_valid,
  input  wire cip_pkg::cip_byte_t vec_data,
  // result
  output var  logic               busy,
  output var  cip_pkg::cip_byte_t vec_got
);
  import cip_pkg::*;
  int cnt;
  initial begin
    ack_b   = 1'b1; // idle high, polling needs no pulses
    busy    = 1'b0;
    vec_got = 8'h00;
    cnt     = 0;
  end
  // slow answer: acknowledge stays low for a fixed span
  always @(negedge clock) begin
    if (!busy && go && init_done) begin // only once init is complete
      ack_b   <= 1'b0;
      busy    <= 1'b1;
      vec_got <= 8'h00;
      cnt     <= 0;
    end else if (busy) begin
      cnt <= cnt + 1;
      if (vec_valid) begin
        vec_got <= vec_data;
      end
      if (cnt == ACK_CYC) begin
        ack_b <= 1'b1;
        busy  <= 1'b0;
      end
    end
  end
endmodule : cip_host_model
`default_nettype wire

//--- cascaded_interrupt_priority_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cascaded_interrupt_priority_tb;
  import cip_pkg::*;
  logic       clock   = 1'b0;
  logic       rst_b   = 1'b0;
  logic       wr_stb  = 1'b0;
  logic       rd_stb  = 1'b0;
  logic       addr0   = 1'b0;
  logic       go      = 1'b0;
  logic       msel    = 1'b0;
  logic [7:0] req_in  = 8'h00;
  logic [2:0] cas_in  = 3'h0;
  cip_byte_t  wdata   = 8'h00;
  cip_byte_t  rdata;
  cip_byte_t  vec_data;
  cip_byte_t  vec_got;
  logic       ack_b;
  logic       vec_valid;
  logic       int_out;
  logic       cas_oe;
  logic [2:0] cas_out;
  logic       init_done;
  logic       busy;
  int         errors    = 0;
  int         cmp_count = 0;

  always #50 clock = ~clock;

  cip_controller i_dut (
    .clock(clock), .rst_b(rst_b), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .addr0(addr0), .wdata(wdata), .rdata(rdata),
    .interrupt_acknowledge_in_b(ack_b), .vec_data(vec_data),
    .vec_valid(vec_valid), .req_in(req_in), .int_out(int_out),
    .master_slave_select(msel), .cas_in(cas_in), .cas_out(cas_out),
    .cas_oe(cas_oe), .init_done(init_done)
  );
  cip_host_model i_host (
    .clock(clock), .go(go), .init_done(init_done), .ack_b(ack_b),
    .vec_valid(vec_valid), .vec_data(vec_data), .busy(busy),
    .vec_got(vec_got)
  );

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic a, input cip_byte_t d);
    @(negedge clock);
    wr_stb = 1'b1;
    addr0  = a;
    wdata  = d;
    @(negedge clock);
    wr_stb = 1'b0;
  endtask : wr

  task automatic rd(input logic a, input cip_byte_t exp);
    @(negedge clock);
    rd_stb = 1'b1;
    addr0  = a;
    @(negedge clock);
    rd_stb = 1'b0;
    @(negedge clock);
    check(rdata, exp);
  endtask : rd

  // cas[3] set: cascade code cas[2:0] driven and no vector (exp 00)
  task automatic ack(input cip_byte_t exp, input logic [3:0] cas);
    @(posedge clock);
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    repeat (2) @(negedge clock);
    check({7'h00, cas_oe}, {7'h00, cas[3]});
    if (cas[3]) begin
      check({5'h00, cas_out}, {5'h00, cas[2:0]});
    end
    for (int i = 0; i < 20 && busy; i++) @(negedge clock);
    check(vec_got, exp);
  endtask : ack

  task automatic settle(input logic [7:0] r);
    req_in = r;
    repeat (2) @(negedge clock);
  endtask : settle

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #300000;
    errors++;
    $display("mismatch at %0t: run did not finish", $time);
    give_verdict;
  end

  initial begin
    repeat (3) @(negedge clock);
    rst_b = 1'b1;
    check({7'h00, init_done}, 8'h00);
    rd(1'b1, 8'hFF);
    // single device, four-byte spacing
    wr(1'b0, 8'h16);
    wr(1'b1, 8'h10);
    check({7'h00, init_done}, 8'h01);
    wr(1'b1, 8'h00);
    rd(1'b1, 8'h00);
    settle(8'h09);
    check({7'h00, int_out}, 8'h01);
    ack(8'h10, 4'h0);
    check({7'h00, int_out}, 8'h00);
    wr(1'b0, 8'h20);
    check({7'h00, int_out}, 8'h01);
    ack(8'h1C, 4'h0);
    wr(1'b0, 8'h20);
    settle(8'h00);
    // stand-alone polled master, ack idle high, two words only
    msel = 1'b1;
    wr(1'b0, 8'h16);
    wr(1'b1, 8'h00);
    check({7'h00, init_done}, 8'h01);
    settle(8'h24);
    rd(1'b0, 8'h24);
    wr(1'b0, 8'h0C);
    rd(1'b0, 8'h82);
    wr(1'b0, 8'h20);
    wr(1'b0, 8'h0C);
    rd(1'b0, 8'h85);
    wr(1'b0, 8'h20);
    settle(8'h00);
    // eight-byte spacing
    wr(1'b0, 8'h12);
    wr(1'b1, 8'h40);
    wr(1'b1, 8'h00);
    settle(8'h20);
    ack(8'h68, 4'h0);
    wr(1'b0, 8'h20);
    settle(8'h00);
    // cascade master, dummy base
    msel = 1'b1;
    wr(1'b0, 8'h14);
    wr(1'b1, 8'h00);
    check({7'h00, init_done}, 8'h00);
    wr(1'b1, 8'hFF);
    check({7'h00, init_done}, 8'h01);
    wr(1'b1, 8'h00);
    settle(8'h10);
    ack(8'h00, 4'hC);
    @(negedge clock);
    check({7'h00, cas_oe}, 8'h00);
    check({7'h00, int_out}, 8'h00);
    wr(1'b0, 8'h20);
    settle(8'h00);
    // cascade slave with id 3
    msel   = 1'b0;
    cas_in = 3'h3;
    wr(1'b0, 8'h14);
    wr(1'b1, 8'h60);
    wr(1'b1, 8'h03);
    wr(1'b1, 8'h00);
    settle(8'h02);
    ack(8'h64, 4'h0);
    give_verdict;
  end
endmodule : cascaded_interrupt_priority_tb
`default_nettype wire
